// File: abf_pkg.sv
package abf_pkg;
    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int                DATA_W       = 8;      // byte-wide bus
    localparam int                RX_DEPTH     = 16;     // receive store entries
    localparam int                TX_DEPTH     = 16;     // transmit store entries
    localparam logic [7:0]        DATA_RST     = 8'h00;  // data regs after reset
    localparam logic              FLAG_IDLE    = 1'b1;   // inactive flag level
    localparam int                SYNC_STAGES  = 2;      // pin synchroniser depth
    // strobe timing kept by the host, in ns and in ref_clk cycles
    localparam int                CLK_PERIOD_NS = 5;
    localparam int                STROBE_LOW_NS = 30;
    localparam int                STROBE_HIGH_NS = 30;
    localparam int                STROBE_LOW_CYC =
        (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int                STROBE_HIGH_CYC =
        (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]        STROBE_LOW_CNT = 8'(STROBE_LOW_CYC);
    localparam logic [7:0]        STROBE_HIGH_CNT = 8'(STROBE_HIGH_CYC);
    localparam logic [7:0]        WAKE_PULSE_CNT = 8'(STROBE_LOW_CYC);
endpackage

// File: abf_if.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// pins between bridge port and external logic
// ------------------------------------------------------------
interface abf_if;
    logic [7:0] bus_from_dev;     // device data drive
    logic       bus_dev_oe;       // device drives bus
    logic [7:0] bus_from_host;    // host data drive
    logic       bus_host_oe;      // host drives bus
    logic       rd_n;             // read strobe
    logic       wr_n;             // write strobe
    logic       rx_byte_ready_n;  // data-available flag level
    logic       rx_flag_oe;       // flag driven (else pulled up)
    logic       tx_room_n;        // space-available flag level
    logic       tx_flag_oe;       // flag driven (else pulled up)
    logic       send_now_wake_n;  // send-immediate / wake
    logic [7:0] bus_wire;         // resolved bus level
    logic       rx_ready_wire;    // resolved flag (pull-up)
    logic       tx_room_wire;     // resolved flag (pull-up)

    // wire resolution with weak pull-up on flags
    assign bus_wire = bus_dev_oe ? bus_from_dev :
                      (bus_host_oe ? bus_from_host : 8'hFF);
    assign rx_ready_wire = rx_flag_oe ? rx_byte_ready_n : 1'b1;
    assign tx_room_wire  = tx_flag_oe ? tx_room_n : 1'b1;

    modport dev (
        output bus_from_dev, bus_dev_oe, rx_byte_ready_n, rx_flag_oe,
        output tx_room_n, tx_flag_oe,
        input  bus_wire, rd_n, wr_n, send_now_wake_n
    );
    modport host (
        output bus_from_host, bus_host_oe, rd_n, wr_n, send_now_wake_n,
        input  bus_wire, rx_ready_wire, tx_room_wire
    );
endinterface

// File: abf_dev.sv
`timescale 1ns/10ps
// Behaviour
// RULE1 - transfers timed by strobe falling edges
// RULE2 - mode active only when configuration selects it
// RULE3 - data bus input unless read strobe low
// RULE4 - data flag low when byte readable
// RULE5 - data flag high after each read rise
// RULE6 - data flag undriven during reset
// RULE7 - room flag high when transmit store full
// RULE8 - host writes by strobing write high-low
// RULE9 - room flag undriven during reset
// RULE10 - read fall presents head receive byte
// RULE11 - read rise advances receive store
// RULE12 - write fall captures bus byte
// RULE13 - wake pulse while suspended requests resume
// RULE14 - wake pulse while running flushes transmit data
// RULE15 - host holds wake input high unused
// RULE16 - write while room flag high ignored
module abf_dev #(
    parameter int RX_DEPTH = abf_pkg::RX_DEPTH,
    parameter int TX_DEPTH = abf_pkg::TX_DEPTH
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    abf_if.dev              pins,
    input  wire logic       mode_sel,        // configuration selects fifo mode
    input  wire logic       wake_enable,     // remote wakeup allowed
    input  wire logic       power_on_n,      // 1 = bus suspended
    input  wire logic [7:0] usb_rx_data,     // byte from usb side
    input  wire logic       usb_rx_valid,    // byte offered
    output logic            usb_rx_ready,    // receive store has room
    output logic [7:0]      usb_tx_data,     // transmit head byte
    output logic            usb_tx_valid,    // transmit byte available
    input  wire logic       usb_tx_ready,    // usb side takes head
    output logic            resume_req,      // one-cycle resume request
    output logic            flush_req        // one-cycle send-now request
);
    localparam int RA = $clog2(RX_DEPTH);
    localparam int TA = $clog2(TX_DEPTH);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q, s1_d;    // first stage, read only by s2
    logic [2:0] s2_q, s2_d;    // second stage {wake,wr,rd}
    logic [2:0] s3_q, s3_d;    // previous synced level for edges
    logic [7:0] bus_s1_q, bus_s1_d;
    logic [7:0] bus_s2_q, bus_s2_d;

    always_comb begin
        s1_d     = {pins.send_now_wake_n, pins.wr_n, pins.rd_n};
        s2_d     = s1_q;
        s3_d     = s2_q;
        bus_s1_d = pins.bus_wire;
        bus_s2_d = bus_s1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_q     <= 3'h7;
            s2_q     <= 3'h7;
            s3_q     <= 3'h7;
            bus_s1_q <= abf_pkg::DATA_RST;
            bus_s2_q <= abf_pkg::DATA_RST;
        end else begin
            s1_q     <= s1_d;
            s2_q     <= s2_d;
            s3_q     <= s3_d;
            bus_s1_q <= bus_s1_d;
            bus_s2_q <= bus_s2_d;
        end
    end

    // edges on synced strobes; mode gate applied to every edge
    logic rd_fall, rd_rise, wr_fall, wake_fall;
    assign rd_fall   = mode_sel && s3_q[0] && !s2_q[0];  // RULE1 RULE2
    assign rd_rise   = mode_sel && !s3_q[0] && s2_q[0];
    assign wr_fall   = mode_sel && s3_q[1] && !s2_q[1];  // RULE1
    assign wake_fall = mode_sel && s3_q[2] && !s2_q[2];

    // ------------------------------------------------------------
    // receive store
    // ------------------------------------------------------------
    logic [7:0]  rx_mem_q [RX_DEPTH];
    logic [7:0]  rx_mem_d [RX_DEPTH];
    logic [RA:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic        rx_full, rx_empty, rx_push, rx_pop;
    logic        rx_hold_q, rx_hold_d;   // flag held high from read fall until one cycle after read ends
    logic [7:0]  out_q, out_d;           // byte driven during read
    logic        oe_q, oe_d;

    assign rx_empty = (rx_wp_q == rx_rp_q);
    assign rx_full  = (rx_wp_q[RA] != rx_rp_q[RA]) && (rx_wp_q[RA-1:0] == rx_rp_q[RA-1:0]);
    assign rx_push  = usb_rx_valid && !rx_full;
    assign rx_pop   = rd_rise && !rx_empty;                 // RULE11

    always_comb begin
        rx_mem_d = rx_mem_q;
        rx_wp_d  = rx_wp_q;
        rx_rp_d  = rx_rp_q;
        out_d    = out_q;
        oe_d     = oe_q;
        rx_hold_d = rx_hold_q;
        if (rx_push) begin
            rx_mem_d[rx_wp_q[RA-1:0]] = usb_rx_data;
            rx_wp_d = rx_wp_q + 1'b1;
        end
        if (rx_pop) begin
            rx_rp_d = rx_rp_q + 1'b1;                       // RULE11
        end
        // drive only while read strobe low
        if (rd_fall) begin
            out_d = rx_mem_q[rx_rp_q[RA-1:0]];              // RULE10
            oe_d  = 1'b1;                                   // RULE3
        end else if (!mode_sel || s2_q[0]) begin
            oe_d  = 1'b0;                                   // RULE3
        end
        // flag rises with read start, stays up one cycle past read end to let pointers settle
        rx_hold_d = rd_rise || (rd_fall ? 1'b1 : (rx_hold_q && !s2_q[0]));  // RULE5
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < RX_DEPTH; i++) rx_mem_q[i] <= abf_pkg::DATA_RST;
            rx_wp_q   <= '0;
            rx_rp_q   <= '0;
            out_q     <= abf_pkg::DATA_RST;
            oe_q      <= 1'b0;
            rx_hold_q <= 1'b0;
        end else begin
            rx_mem_q  <= rx_mem_d;
            rx_wp_q   <= rx_wp_d;
            rx_rp_q   <= rx_rp_d;
            out_q     <= out_d;
            oe_q      <= oe_d;
            rx_hold_q <= rx_hold_d;
        end
    end

    // ------------------------------------------------------------
    // transmit store
    // ------------------------------------------------------------
    logic [7:0]  tx_mem_q [TX_DEPTH];
    logic [7:0]  tx_mem_d [TX_DEPTH];
    logic [TA:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
    logic        tx_full, tx_empty, tx_push;
    logic        room_n_q, room_n_d;     // room flag, also gates the push

    assign tx_empty = (tx_wp_q == tx_rp_q);
    assign tx_full  = (tx_wp_q[TA] != tx_rp_q[TA]) && (tx_wp_q[TA-1:0] == tx_rp_q[TA-1:0]);
    // a write while the room flag shows full stores nothing
    assign tx_push  = wr_fall && !tx_full && !room_n_q;      // RULE12 RULE16

    always_comb begin
        tx_mem_d = tx_mem_q;
        tx_wp_d  = tx_wp_q;
        tx_rp_d  = tx_rp_q;
        if (tx_push) begin
            tx_mem_d[tx_wp_q[TA-1:0]] = bus_s2_q;            // RULE12
            tx_wp_d = tx_wp_q + 1'b1;
        end
        if (usb_tx_ready && !tx_empty) begin
            tx_rp_d = tx_rp_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < TX_DEPTH; i++) tx_mem_q[i] <= abf_pkg::DATA_RST;
            tx_wp_q <= '0;
            tx_rp_q <= '0;
        end else begin
            tx_mem_q <= tx_mem_d;
            tx_wp_q  <= tx_wp_d;
            tx_rp_q  <= tx_rp_d;
        end
    end

    // ------------------------------------------------------------
    // flags, usb-side outputs and wake handling
    // ------------------------------------------------------------
    logic rx_flag_q, rx_flag_d, fl_oe_q, fl_oe_d;
    logic rdy_q, rdy_d, txv_q, txv_d, res_q, res_d, fls_q, fls_d;
    logic [7:0] txd_q, txd_d;

    always_comb begin
        rx_flag_d = !mode_sel || rx_empty || rx_hold_d || rx_pop;  // RULE4 RULE5
        room_n_d = !mode_sel || tx_full || (tx_push &&
                   (tx_wp_q[TA-1:0] + 1'b1 == tx_rp_q[TA-1:0]));   // RULE7
        fl_oe_d  = 1'b1;
        rdy_d    = !rx_full && !(rx_push &&
                   (rx_wp_q[RA-1:0] + 1'b1 == rx_rp_q[RA-1:0]));
        txv_d    = !tx_empty;
        txd_d    = tx_mem_q[tx_rp_q[TA-1:0]];
        res_d    = wake_fall && power_on_n && wake_enable;         // RULE13
        fls_d    = wake_fall && !power_on_n;                       // RULE14
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_flag_q <= abf_pkg::FLAG_IDLE;
            room_n_q <= abf_pkg::FLAG_IDLE;
            fl_oe_q  <= 1'b0;                                      // RULE6 RULE9
            rdy_q    <= 1'b0;
            txv_q    <= 1'b0;
            txd_q    <= abf_pkg::DATA_RST;
            res_q    <= 1'b0;
            fls_q    <= 1'b0;
        end else begin
            rx_flag_q <= rx_flag_d;
            room_n_q <= room_n_d;
            fl_oe_q  <= fl_oe_d;
            rdy_q    <= rdy_d;
            txv_q    <= txv_d;
            txd_q    <= txd_d;
            res_q    <= res_d;
            fls_q    <= fls_d;
        end
    end

    // the registered outputs reach the carrier unchanged
    assign pins.bus_from_dev    = out_q;
    assign pins.bus_dev_oe      = oe_q;
    assign pins.rx_byte_ready_n = rx_flag_q;
    assign pins.rx_flag_oe      = fl_oe_q;
    assign pins.tx_room_n       = room_n_q;
    assign pins.tx_flag_oe      = fl_oe_q;
    assign usb_rx_ready = rdy_q;
    assign usb_tx_valid = txv_q;
    assign usb_tx_data  = txd_q;
    assign resume_req   = res_q;
    assign flush_req    = fls_q;
endmodule

// File: abf_host.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// external master: one read or write per request
// ------------------------------------------------------------
module abf_host (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    abf_if.host             pins,
    input  wire logic       rd_req,      // pulse: read one byte
    input  wire logic       wr_req,      // pulse: write wr_data
    input  wire logic [7:0] wr_data,
    input  wire logic       wake_req,    // pulse: strobe wake low
    output logic            busy,        // transfer in progress
    output logic [7:0]      rd_data,
    output logic            rd_valid,    // one-cycle pulse
    output logic            wr_done,     // one-cycle pulse
    output logic            refused      // request refused by flag
);
    typedef enum logic [2:0] {HS_IDLE, HS_RD_LOW, HS_RD_HIGH, HS_WR_LOW,
                              HS_WR_HIGH, HS_WAKE} abf_hst_t;

    // synchronise flags and bus
    logic [1:0] f1_q, f2_q;
    logic [7:0] b1_q, b2_q;
    abf_hst_t   st_q, st_d;
    logic [7:0] cnt_q, cnt_d, wd_q, wd_d, rdd_q, rdd_d;
    logic       rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d, wk_q, wk_d;
    logic       rv_q, rv_d, wd_done_q, wd_done_d, ref_q, ref_d;

    always_comb begin
        st_d = st_q; cnt_d = cnt_q; wd_d = wd_q; rdd_d = rdd_q;
        rd_n_d = rd_n_q; wr_n_d = wr_n_q; oe_d = oe_q; wk_d = wk_q;
        rv_d = 1'b0; wd_done_d = 1'b0; ref_d = 1'b0;
        if (cnt_q != 8'h00) cnt_d = cnt_q - 8'h01;
        case (st_q)
            HS_IDLE: begin
                wk_d = 1'b1;                                   // RULE15
                if (rd_req) begin
                    if (f2_q[0]) ref_d = 1'b1;                 // RULE4
                    else begin
                        rd_n_d = 1'b0; st_d = HS_RD_LOW;
                        cnt_d = abf_pkg::STROBE_LOW_CNT;
                    end
                end else if (wr_req) begin
                    if (f2_q[1]) ref_d = 1'b1;                 // RULE7
                    else begin
                        wd_d = wr_data; oe_d = 1'b1; st_d = HS_WR_LOW;
                        cnt_d = abf_pkg::STROBE_LOW_CNT;
                    end
                end else if (wake_req) begin
                    wk_d = 1'b0; st_d = HS_WAKE;
                    cnt_d = abf_pkg::WAKE_PULSE_CNT;
                end
            end
            HS_RD_LOW: if (cnt_q == 8'h00) begin
                rdd_d = b2_q; rv_d = 1'b1; rd_n_d = 1'b1;
                st_d = HS_RD_HIGH; cnt_d = abf_pkg::STROBE_HIGH_CNT;
            end
            // data set up, then write strobe falls
            HS_WR_LOW: if (cnt_q == 8'h00) begin
                wr_n_d = 1'b0; st_d = HS_WR_HIGH;                 // RULE8
                cnt_d = abf_pkg::STROBE_HIGH_CNT;
            end
            HS_WR_HIGH: if (cnt_q == 8'h00) begin
                wr_n_d = 1'b1; oe_d = 1'b0; wd_done_d = 1'b1;     // RULE8
                st_d = HS_RD_HIGH; cnt_d = abf_pkg::STROBE_HIGH_CNT;
            end
            HS_WAKE: if (cnt_q == 8'h00) begin
                wk_d = 1'b1; st_d = HS_RD_HIGH;
                cnt_d = abf_pkg::STROBE_HIGH_CNT;
            end
            // recovery gap, also lets the device flags settle
            default: if (cnt_q == 8'h00) st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            f1_q <= 2'h3; f2_q <= 2'h3; b1_q <= 8'h00; b2_q <= 8'h00;
            st_q <= HS_IDLE; cnt_q <= 8'h00; wd_q <= 8'h00; rdd_q <= 8'h00;
            rd_n_q <= 1'b1; wr_n_q <= 1'b1; oe_q <= 1'b0; wk_q <= 1'b1;
            rv_q <= 1'b0; wd_done_q <= 1'b0; ref_q <= 1'b0;
        end else begin
            f1_q <= {pins.tx_room_wire, pins.rx_ready_wire}; f2_q <= f1_q;
            b1_q <= pins.bus_wire; b2_q <= b1_q;
            st_q <= st_d; cnt_q <= cnt_d; wd_q <= wd_d; rdd_q <= rdd_d;
            rd_n_q <= rd_n_d; wr_n_q <= wr_n_d; oe_q <= oe_d; wk_q <= wk_d;
            rv_q <= rv_d; wd_done_q <= wd_done_d; ref_q <= ref_d;
        end
    end

    assign pins.rd_n            = rd_n_q;
    assign pins.wr_n            = wr_n_q;
    assign pins.bus_from_host   = wd_q;
    assign pins.bus_host_oe     = oe_q;
    assign pins.send_now_wake_n = wk_q;
    assign busy     = (st_q != HS_IDLE);
    assign rd_data  = rdd_q;
    assign rd_valid = rv_q;
    assign wr_done  = wd_done_q;
    assign refused  = ref_q;
endmodule

// File: abf_chk.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// pin-level checker for the byte port link
// ------------------------------------------------------------
module abf_chk (
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       bus_dev_oe,      // device drives bus
    input wire logic [7:0] bus_from_dev,    // device data
    input wire logic       bus_host_oe,     // host drives bus
    input wire logic       rd_n,            // read strobe
    input wire logic       wr_n,            // write strobe
    input wire logic       rx_flag_oe,      // data flag driven
    input wire logic       tx_flag_oe,      // room flag driven
    input wire logic       rx_ready_wire,   // resolved data flag
    input wire logic       send_now_wake_n  // wake input
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // reset checks keep running inside reset on purpose
    AST_RX_FLAG_FLOAT: assert property (disable iff (1'b0) !rst_b |=> !rx_flag_oe)
        else $error("data flag driven during reset");
    AST_TX_FLAG_FLOAT: assert property (disable iff (1'b0) !rst_b |=> !tx_flag_oe)
        else $error("room flag driven during reset");
    AST_BUS_DRIVE_IN_READ: assert property ($rose(bus_dev_oe) |-> !rd_n)
        else $error("device drove bus without read strobe");
    AST_BUS_RELEASE: assert property (rd_n [*4] |-> !bus_dev_oe)
        else $error("device kept bus after read strobe");
    AST_READ_ANSWER: assert property ($fell(rd_n) |-> ##[2:5] bus_dev_oe)
        else $error("no data after read fall");
    AST_READ_DATA_HOLD: assert property (bus_dev_oe && $past(bus_dev_oe) |-> $stable(bus_from_dev))
        else $error("read data changed while driven");
    AST_FLAG_AFTER_READ: assert property ($rose(rd_n) |-> ##[0:4] rx_ready_wire)
        else $error("data flag not raised after read");
    AST_READ_ONLY_READY: assert property ($fell(rd_n) |-> !$past(rx_ready_wire))
        else $error("read started with no data");
    AST_WRITE_DATA_ON: assert property (!wr_n |-> bus_host_oe && !bus_dev_oe)
        else $error("write strobe low without host data");
    AST_WAKE_PULSE: assert property ($fell(send_now_wake_n) |-> ##[1:8] send_now_wake_n)
        else $error("wake input not returned high");

    // main traffic seen at least once
    COV_READ: cover property ($rose(bus_dev_oe));
    COV_WRITE: cover property ($fell(wr_n));
    COV_WAKE: cover property ($fell(send_now_wake_n));
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// link bench: host end against device end
// ------------------------------------------------------------
module tb_top;
    logic       ref_clk;        // 200 MHz
    logic       rst_b;          // sync reset, active low
    logic       mode_sel;       // fifo mode selected
    logic       wake_enable;    // remote wake allowed
    logic       power_on_n;     // 1 = suspended
    logic [7:0] usb_rx_data;    // usb side byte in
    logic       usb_rx_valid;
    logic       usb_rx_ready;
    logic [7:0] usb_tx_data;    // usb side byte out
    logic       usb_tx_valid;
    logic       usb_tx_ready;
    logic       resume_req;
    logic       flush_req;
    logic       rd_req;         // host user side
    logic       wr_req;
    logic       wake_req;
    logic [7:0] wr_data;
    logic       busy;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       wr_done;
    logic       refused;
    int         err_total;
    int         samples_checked;
    int         flush_cnt;      // pulses seen on usb side
    int         resume_cnt;
    logic [7:0] got;
    logic       ok;

    abf_if link ();
    abf_dev abf_dev_inst (.ref_clk(ref_clk), .rst_b(rst_b), .pins(link.dev),
        .mode_sel(mode_sel), .wake_enable(wake_enable), .power_on_n(power_on_n),
        .usb_rx_data(usb_rx_data), .usb_rx_valid(usb_rx_valid),
        .usb_rx_ready(usb_rx_ready), .usb_tx_data(usb_tx_data),
        .usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready),
        .resume_req(resume_req), .flush_req(flush_req));
    abf_host abf_host_inst (.ref_clk(ref_clk), .rst_b(rst_b), .pins(link.host),
        .rd_req(rd_req), .wr_req(wr_req), .wr_data(wr_data), .wake_req(wake_req),
        .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .wr_done(wr_done),
        .refused(refused));
    abf_chk abf_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus_dev_oe(link.bus_dev_oe),
        .bus_from_dev(link.bus_from_dev), .bus_host_oe(link.bus_host_oe),
        .rd_n(link.rd_n), .wr_n(link.wr_n), .rx_flag_oe(link.rx_flag_oe),
        .tx_flag_oe(link.tx_flag_oe), .rx_ready_wire(link.rx_ready_wire),
        .send_now_wake_n(link.send_now_wake_n));

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // count one-cycle usb side pulses
    always @(posedge ref_clk) begin
        if (flush_req === 1'b1) flush_cnt++;
        if (resume_req === 1'b1) resume_cnt++;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // one host request: 0 read, 1 write, 2 wake; ok low when refused
    task automatic host_op(input int kind, input logic [7:0] d);
        int n;
        for (n = 0; n < 200 && busy !== 1'b0; n++) idle(1);
        if (n == 200) err_total++;
        @(posedge ref_clk);
        rd_req <= (kind == 0);
        wr_req <= (kind == 1);
        wake_req <= (kind == 2);
        wr_data <= d;
        @(posedge ref_clk);
        {rd_req, wr_req, wake_req} <= 3'h0;
        ok = 1'b0;
        got = 8'h00;
        // look first: the refused pulse stands only in the cycle right after the request
        #1;
        for (n = 0; n < 200; n++) begin
            if (rd_valid === 1'b1 || wr_done === 1'b1 || (kind == 2 && busy === 1'b0)) begin
                got = rd_data;
                ok = 1'b1;
                break;
            end
            if (refused === 1'b1) break;
            idle(1);
        end
        if (n == 200) begin
            err_total++;
            print_verdict();
        end
    endtask

    // usb side offers one byte to the receive store
    task automatic usb_push(input logic [7:0] d);
        int  n;
        logic taken;
        @(posedge ref_clk);
        usb_rx_data <= d;
        usb_rx_valid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            #1 taken = (usb_rx_ready === 1'b1);
            @(posedge ref_clk);
            if (taken) break;
        end
        usb_rx_valid <= 1'b0;
        if (n == 100) err_total++;
    endtask

    initial begin
        {rd_req, wr_req, wake_req, usb_rx_valid, usb_tx_ready} = 5'h00;
        {wr_data, usb_rx_data} = 16'h0000;
        {mode_sel, wake_enable, power_on_n} = 3'h4;
        err_total = 0;
        samples_checked = 0;
        flush_cnt = 0;
        resume_cnt = 0;
        rst_b = 1'b0;
        idle(10);
        chk("data flag in reset", 8'h01, {7'h00, link.rx_ready_wire});
        chk("room flag in reset", 8'h01, {7'h00, link.tx_room_wire});
        @(posedge ref_clk) rst_b <= 1'b1;
        idle(6);
        $display("test reset done");

        // empty store: read refused, flag high
        host_op(0, 8'h00);
        chk("empty read ok", 8'h00, {7'h00, ok});
        usb_push(8'hA5);
        usb_push(8'h3C);
        usb_push(8'h01);
        idle(10);
        chk("data flag ready", 8'h00, {7'h00, link.rx_ready_wire});
        host_op(0, 8'h00);
        chk("read byte 0", 8'hA5, got);
        host_op(0, 8'h00);
        chk("read byte 1", 8'h3C, got);
        host_op(0, 8'h00);
        chk("read byte 2", 8'h01, got);
        idle(10);
        chk("data flag drained", 8'h01, {7'h00, link.rx_ready_wire});
        $display("test read done");

        // fill transmit store while usb side stalls, then drain
        for (int i = 0; i < 16; i++) begin
            host_op(1, 8'(8'h10 + i));
            chk("write taken", 8'h01, {7'h00, ok});
        end
        idle(10);
        chk("room flag full", 8'h01, {7'h00, link.tx_room_wire});
        host_op(1, 8'hEE);
        chk("full write ok", 8'h00, {7'h00, ok});
        for (int i = 0; i < 16; i++) begin
            chk("tx valid", 8'h01, {7'h00, usb_tx_valid});
            chk("tx byte", 8'(8'h10 + i), usb_tx_data);
            @(posedge ref_clk) usb_tx_ready <= 1'b1;
            @(posedge ref_clk) usb_tx_ready <= 1'b0;
            // registered head byte shows the new entry one edge after the pop
            idle(1);
        end
        chk("tx empty", 8'h00, {7'h00, usb_tx_valid});
        idle(10);
        chk("room flag free", 8'h00, {7'h00, link.tx_room_wire});
        $display("test write done");

        // wake input in running, suspended, and disabled states
        host_op(2, 8'h00);
        idle(10);
        chk("flush pulses", 8'h01, 8'(flush_cnt));
        chk("resume idle", 8'h00, 8'(resume_cnt));
        @(posedge ref_clk);
        power_on_n <= 1'b1;
        wake_enable <= 1'b1;
        host_op(2, 8'h00);
        idle(10);
        chk("resume pulses", 8'h01, 8'(resume_cnt));
        @(posedge ref_clk);
        wake_enable <= 1'b0;
        host_op(2, 8'h00);
        idle(10);
        chk("resume masked", 8'h01, 8'(resume_cnt));
        chk("flush in suspend", 8'h01, 8'(flush_cnt));
        $display("test wake done");

        // mode not selected: flags stay high
        @(posedge ref_clk) mode_sel <= 1'b0;
        usb_push(8'h5A);
        idle(10);
        chk("data flag off mode", 8'h01, {7'h00, link.rx_ready_wire});
        chk("room flag off mode", 8'h01, {7'h00, link.tx_room_wire});
        $display("test mode done");
        print_verdict();
    end
endmodule
